// ### core/urx_rx_core.sv
// Asynchronous serial receiver with start-bit validation and AHB-Lite registers
`default_nettype none

module urx_rx_core #(
    parameter logic [11:0] BAUD_DIV_RST = urx_pkg::BAUD_RST
) (
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic      [31:0] hrdata,
    input  wire logic        rxd,
    output logic             rxPinOverride,
    output logic             rxIrq
);
    localparam int CW = $clog2(urx_pkg::BUF_DEPTH + 1);

    // Register state
    logic        dblSpeed_q;
    logic        irqEn_q;
    logic        rxEn_q;
    logic [5:0]  format_q;
    logic [11:0] baudDiv_q;

    // Bus pipeline
    logic        dValid_q;
    logic        dWrite_q;
    logic [7:0]  dAddr_q;
    logic        rdDone_q;
    logic [31:0] hrdata_q;
    logic        rdNow;
    logic        wrNow;
    logic [31:0] rdMux;

    // Line sampling and timing
    logic        sync1_q;
    logic        sync2_q;
    logic        sync3_q;
    logic        rxLvl_q;
    logic        lastLvl_q;
    logic [11:0] presc_q;
    logic        tick;
    logic [4:0]  smpPerBit;
    logic [4:0]  voteFirst;

    // Receiver state
    urx_pkg::urx_state_t state_q;
    logic [4:0]  smpCnt_q;
    logic [1:0]  votes_q;
    logic [3:0]  bitIdx_q;
    logic [8:0]  shData_q;
    logic        parBit_q;
    logic [3:0]  nData;
    logic [3:0]  lastIdx;
    logic        voteHigh;
    logic        decide;
    logic        frameDone;

    // Waiting frame and buffer
    logic                    pendValid_q;
    logic [urx_pkg::ENT_W-1:0] pend_q;
    logic                    ovrSeen_q;
    logic                    ovrSet;
    logic                    bufPush;
    logic                    bufPop;
    logic [urx_pkg::ENT_W-1:0] head;
    logic [CW-1:0]           count;
    logic                    full;
    logic                    haveData;
    logic [urx_pkg::ENT_W-1:0] headShown;
    logic                    parErr;

    // Bus slave: one wait state on reads so hrdata is a flop
    assign rdNow = dValid_q && !dWrite_q && !rdDone_q;
    assign wrNow = dValid_q && dWrite_q;
    assign hreadyout = !rdNow;
    assign hresp = 1'b0;
    assign hrdata = hrdata_q;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            dValid_q <= 1'b0;
            dWrite_q <= 1'b0;
            dAddr_q  <= urx_pkg::OFS_NONE;
            rdDone_q <= 1'b0;
        end else if (hready) begin
            dValid_q <= hsel && htrans[1] && hsize == 3'h2;
            dWrite_q <= hwrite;
            dAddr_q  <= (haddr[31:8] == 24'h000000) ? haddr[7:0] : urx_pkg::OFS_NONE;
            rdDone_q <= 1'b0;
        end else if (rdNow) begin
            rdDone_q <= 1'b1;
        end
    end

    // Gated by enable so a disable empties the view at once, not one clock later
    assign haveData  = (count != '0) && rxEn_q;
    assign headShown = haveData ? head : '0;

    always_comb begin
        rdMux = 32'h00000000;
        unique case (dAddr_q)
            urx_pkg::OFS_STATUS: begin
                rdMux[urx_pkg::SB_RXC] = haveData;
                rdMux[urx_pkg::SB_FE]  = headShown[urx_pkg::ENT_FE];
                rdMux[urx_pkg::SB_OVR] = headShown[urx_pkg::ENT_OVR];
                rdMux[urx_pkg::SB_PE]  = headShown[urx_pkg::ENT_PE];
                rdMux[urx_pkg::SB_DBL] = dblSpeed_q;
            end
            urx_pkg::OFS_CONTROL: begin
                rdMux[urx_pkg::CB_IRQEN] = irqEn_q;
                rdMux[urx_pkg::CB_RXEN]  = rxEn_q;
                rdMux[urx_pkg::CB_NINTH] = headShown[8];
            end
            urx_pkg::OFS_FORMAT: rdMux[5:0] = format_q;
            urx_pkg::OFS_DATA:   rdMux[7:0] = headShown[7:0];
            urx_pkg::OFS_BAUD:   rdMux[11:0] = baudDiv_q;
            default:             rdMux = 32'h00000000;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            hrdata_q <= 32'h00000000;
        end else if (rdNow) begin
            hrdata_q <= rdMux;
        end
    end

    assign bufPop = rdNow && dAddr_q == urx_pkg::OFS_DATA;

    // Error flag positions are not writable
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            dblSpeed_q <= urx_pkg::DBL_RST;
        end else if (wrNow && dAddr_q == urx_pkg::OFS_STATUS) begin
            dblSpeed_q <= hwdata[urx_pkg::SB_DBL];
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            irqEn_q <= urx_pkg::IRQEN_RST;
            rxEn_q  <= urx_pkg::RXEN_RST;
        end else if (wrNow && dAddr_q == urx_pkg::OFS_CONTROL) begin
            irqEn_q <= hwdata[urx_pkg::CB_IRQEN];
            rxEn_q  <= hwdata[urx_pkg::CB_RXEN];
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            format_q  <= urx_pkg::FORMAT_RST;
            baudDiv_q <= BAUD_DIV_RST;
        end else if (wrNow && dAddr_q == urx_pkg::OFS_FORMAT) begin
            format_q <= hwdata[5:0];
        end else if (wrNow && dAddr_q == urx_pkg::OFS_BAUD) begin
            baudDiv_q <= hwdata[11:0];
        end
    end

    // Only the buffer flag drives the request, never the error flags
    assign rxIrq = haveData && irqEn_q;
    assign rxPinOverride = rxEn_q;

    // Three-stage sync; level accepted once stages two and three agree
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            sync1_q <= 1'b1;
            sync2_q <= 1'b1;
            sync3_q <= 1'b1;
            rxLvl_q <= 1'b1;
        end else begin
            sync1_q <= rxd;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
            if (sync2_q == sync3_q) begin
                rxLvl_q <= sync3_q;
            end
        end
    end

    // Sample tick every baudDiv+1 clocks
    always_ff @(posedge clk) begin
        if (!rst_b || presc_q == 12'h000) begin
            presc_q <= baudDiv_q;
        end else begin
            presc_q <= presc_q - 12'h001;
        end
    end
    assign tick = (presc_q == 12'h000);

    assign smpPerBit = dblSpeed_q ? urx_pkg::SMP_DOUBLE : urx_pkg::SMP_NORMAL;
    assign voteFirst = dblSpeed_q ? urx_pkg::VOTE_DOUBLE : urx_pkg::VOTE_NORMAL;

    always_comb begin
        unique case (format_q[urx_pkg::FB_SIZE +: 3])
            urx_pkg::SZ_5: nData = 4'h5;
            urx_pkg::SZ_6: nData = 4'h6;
            urx_pkg::SZ_7: nData = 4'h7;
            urx_pkg::SZ_9: nData = 4'h9;
            default:       nData = 4'h8;
        endcase
    end

    // Stop index ignores the stop-count select: one stop bit checked
    assign lastIdx = nData + {3'h0, format_q[urx_pkg::FB_PAREN]};

    assign voteHigh = ({1'b0, votes_q} + {2'h0, rxLvl_q}) >= 3'h2;
    assign decide = tick && state_q != urx_pkg::RS_IDLE
                    && smpCnt_q == voteFirst + 5'h02;
    assign frameDone = decide && state_q == urx_pkg::RS_BITS && bitIdx_q == lastIdx;

    always_ff @(posedge clk) begin
        if (!rst_b || !rxEn_q) begin
            state_q   <= urx_pkg::RS_IDLE;
            lastLvl_q <= 1'b0;
            smpCnt_q  <= 5'h00;
            votes_q   <= 2'h0;
            bitIdx_q  <= 4'h0;
        end else if (tick) begin
            unique case (state_q)
                urx_pkg::RS_IDLE: begin
                    lastLvl_q <= rxLvl_q;
                    if (lastLvl_q && !rxLvl_q) begin
                        state_q  <= urx_pkg::RS_START;
                        smpCnt_q <= 5'h02;
                        votes_q  <= 2'h0;
                    end
                end
                default: begin
                    smpCnt_q <= (smpCnt_q == smpPerBit) ? 5'h01 : smpCnt_q + 5'h01;
                    if (smpCnt_q >= voteFirst && smpCnt_q < voteFirst + 5'h02) begin
                        votes_q <= votes_q + {1'b0, rxLvl_q};
                    end
                    if (decide) begin
                        votes_q <= 2'h0;
                        if (state_q == urx_pkg::RS_START && voteHigh) begin
                            state_q   <= urx_pkg::RS_IDLE;
                            lastLvl_q <= 1'b1;
                        end else if (frameDone) begin
                            state_q   <= urx_pkg::RS_IDLE;
                            lastLvl_q <= voteHigh;
                        end else if (state_q == urx_pkg::RS_BITS) begin
                            bitIdx_q <= bitIdx_q + 4'h1;
                        end
                    end
                    if (state_q == urx_pkg::RS_START && smpCnt_q == smpPerBit) begin
                        state_q  <= urx_pkg::RS_BITS;
                        bitIdx_q <= 4'h0;
                    end
                end
            endcase
        end
    end

    // Shift data cleared per frame so short characters read zero-filled
    always_ff @(posedge clk) begin
        if (!rst_b || state_q == urx_pkg::RS_START) begin
            shData_q <= 9'h000;
            parBit_q <= 1'b0;
        end else if (decide && state_q == urx_pkg::RS_BITS) begin
            if (bitIdx_q < nData) begin
                shData_q[bitIdx_q] <= voteHigh;
            end else if (bitIdx_q != lastIdx) begin
                parBit_q <= voteHigh;
            end
        end
    end

    // Even check: data xor parity is zero; odd check: it is one
    assign parErr = format_q[urx_pkg::FB_PAREN]
                    && (^shData_q ^ parBit_q ^ format_q[urx_pkg::FB_PARODD]);

    // Overrun: new start while buffer full and a frame waits
    assign ovrSet = tick && state_q == urx_pkg::RS_IDLE && lastLvl_q && !rxLvl_q
                    && full && pendValid_q;
    assign bufPush = pendValid_q && !full;

    always_ff @(posedge clk) begin
        if (!rst_b || !rxEn_q) begin
            ovrSeen_q <= 1'b0;
        end else if (ovrSet || (frameDone && pendValid_q && !bufPush)) begin
            ovrSeen_q <= 1'b1;
        end else if (bufPush) begin
            ovrSeen_q <= 1'b0;
        end
    end

    // Waiting frame; a frame finishing while one still waits is lost
    always_ff @(posedge clk) begin
        if (!rst_b || !rxEn_q) begin
            pendValid_q <= 1'b0;
            pend_q      <= '0;
        end else if (frameDone && (!pendValid_q || bufPush)) begin
            pendValid_q <= 1'b1;
            pend_q[8:0] <= shData_q;
            pend_q[urx_pkg::ENT_FE] <= !voteHigh;
            pend_q[urx_pkg::ENT_PE] <= parErr;
            pend_q[urx_pkg::ENT_OVR] <= 1'b0;
        end else if (bufPush) begin
            pendValid_q <= 1'b0;
        end
    end

    urx_rx_fifo #(
        .W (urx_pkg::ENT_W),
        .D (urx_pkg::BUF_DEPTH)
    ) u_buf (
        .clk      (clk),
        .rst_b    (rst_b),
        .flush    (!rxEn_q),
        .push     (bufPush),
        .pushData ({ovrSeen_q || ovrSet, pend_q[urx_pkg::ENT_W-2:0]}),
        .pop      (bufPop),
        .head     (head),
        .count    (count),
        .full     (full)
    );

endmodule

`default_nettype wire

// ### core/urx_rx_fifo.sv
// Receive buffer: small shift FIFO whose head entry is a register
`default_nettype none

module urx_rx_fifo #(
    parameter int W = 12,
    parameter int D = 2
) (
    input  wire logic                 clk,
    input  wire logic                 rst_b,
    input  wire logic                 flush,
    input  wire logic                 push,
    input  wire logic [W-1:0]         pushData,
    input  wire logic                 pop,
    output logic      [W-1:0]         head,
    output logic      [$clog2(D+1)-1:0] count,
    output logic                      full
);
    localparam int CW = $clog2(D+1);

    logic [W-1:0]  ent_q [D];
    logic [CW-1:0] cnt_q;
    logic          doPop;
    logic          doPush;

    if (D < 1) begin : g_chk
        $error("urx_rx_fifo depth must be at least one");
    end

    assign doPop  = pop && (cnt_q != '0);
    assign doPush = push && (cnt_q != CW'(D) || doPop);

    // Entries shift toward the head on a pop
    for (genvar i = 0; i < D; i++) begin : g_ent
        always_ff @(posedge clk) begin
            if (!rst_b) begin
                ent_q[i] <= '0;
            end else if (!flush) begin
                if (doPop) begin
                    if (doPush && cnt_q == CW'(i + 1)) begin
                        ent_q[i] <= pushData;
                    end else if (i < D - 1) begin
                        ent_q[i] <= ent_q[(i < D - 1) ? i + 1 : i];
                    end
                end else if (doPush && cnt_q == CW'(i)) begin
                    ent_q[i] <= pushData;
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b || flush) begin
            cnt_q <= '0;
        end else if (doPush && !doPop) begin
            cnt_q <= cnt_q + CW'(1);
        end else if (doPop && !doPush) begin
            cnt_q <= cnt_q - CW'(1);
        end
    end

    assign head  = ent_q[0];
    assign count = cnt_q;
    assign full  = (cnt_q == CW'(D));

endmodule

`default_nettype wire

// ### inc/urx_pkg.sv
// Shared constants and types for the serial receiver block
`default_nettype none

package urx_pkg;

    // Register byte offsets
    localparam logic [7:0] OFS_STATUS  = 8'h00;
    localparam logic [7:0] OFS_CONTROL = 8'h04;
    localparam logic [7:0] OFS_FORMAT  = 8'h08;
    localparam logic [7:0] OFS_DATA    = 8'h0c;
    localparam logic [7:0] OFS_BAUD    = 8'h10;
    localparam logic [7:0] OFS_NONE    = 8'hff;

    // Status register bit positions
    localparam int SB_RXC = 7;
    localparam int SB_FE  = 4;
    localparam int SB_OVR = 3;
    localparam int SB_PE  = 2;
    localparam int SB_DBL = 1;

    // Control register bit positions
    localparam int CB_IRQEN = 7;
    localparam int CB_RXEN  = 4;
    localparam int CB_NINTH = 1;

    // Format register bit positions
    localparam int FB_PAREN  = 5;
    localparam int FB_PARODD = 4;
    localparam int FB_STOP2  = 3;
    localparam int FB_SIZE   = 0;

    // Values after reset
    localparam logic        DBL_RST    = 1'b0;
    localparam logic        IRQEN_RST  = 1'b0;
    localparam logic        RXEN_RST   = 1'b0;
    localparam logic [5:0]  FORMAT_RST = 6'h03;
    localparam logic [11:0] BAUD_RST   = 12'h00c;

    // Character size codes
    localparam logic [2:0] SZ_5 = 3'h0;
    localparam logic [2:0] SZ_6 = 3'h1;
    localparam logic [2:0] SZ_7 = 3'h2;
    localparam logic [2:0] SZ_8 = 3'h3;
    localparam logic [2:0] SZ_9 = 3'h7;

    // Oversampling: samples per bit and first voting sample
    localparam logic [4:0] SMP_NORMAL  = 5'h10;
    localparam logic [4:0] SMP_DOUBLE  = 5'h08;
    localparam logic [4:0] VOTE_NORMAL = 5'h08;
    localparam logic [4:0] VOTE_DOUBLE = 5'h04;

    // Receive buffer entry layout
    localparam int ENT_W   = 12;
    localparam int ENT_PE  = 9;
    localparam int ENT_FE  = 10;
    localparam int ENT_OVR = 11;
    localparam int BUF_DEPTH = 2;

    typedef enum logic [1:0] {
        RS_IDLE,
        RS_START,
        RS_BITS
    } urx_state_t;

endpackage

`default_nettype wire

// ### verification/urx_rx_core_assertions.sv
// Port checker for the serial receiver, bound to its top module
`default_nettype none

module urx_rx_core_assertions (
    input wire logic        clk,
    input wire logic        rst_b,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [2:0]  hsize,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic [31:0] hrdata,
    input wire logic        rxd,
    input wire logic        rxPinOverride,
    input wire logic        rxIrq
);
    logic        take;
    logic        phRd_q;
    logic        phWr_q;
    logic [31:0] adr_q;
    logic        irqEn_q;
    logic        rxEn_q;

    assign take = hsel && hready && htrans[1] && hsize == 3'b010;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            phRd_q <= 1'b0;
            phWr_q <= 1'b0;
            adr_q  <= 32'h0;
        end else if (hready) begin
            phRd_q <= take && !hwrite;
            phWr_q <= take && hwrite;
            adr_q  <= haddr;
        end
    end

    // Shadow of the control bits, updated at the write data-phase end
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            irqEn_q <= urx_pkg::IRQEN_RST;
            rxEn_q  <= urx_pkg::RXEN_RST;
        end else if (hready && phWr_q && adr_q == 32'(urx_pkg::OFS_CONTROL)) begin
            irqEn_q <= hwdata[urx_pkg::CB_IRQEN];
            rxEn_q  <= hwdata[urx_pkg::CB_RXEN];
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);

    a_rd_wait_state: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read data phase without exactly one wait state");
    a_wr_no_wait: assert property (take && hwrite |=> hreadyout)
        else $error("write data phase stalled");
    a_unmapped_zero: assert property (take && !hwrite && haddr[31:8] != 24'h0 |-> ##2 hrdata == 32'h0)
        else $error("unmapped read returned nonzero data");
    a_ready_low_read: assert property (!hreadyout |-> phRd_q)
        else $error("wait state outside a read data phase");
    a_resp_okay: assert property (hresp == 1'b0)
        else $error("error response issued");
    a_irq_masked: assert property (rxIrq |-> irqEn_q && rxEn_q)
        else $error("interrupt requested while masked or disabled");
    a_pin_follows_en: assert property (rxPinOverride == rxEn_q)
        else $error("pin override differs from receiver enable");
    a_irq_holds: assert property (rxIrq && !phWr_q &&
        !(phRd_q && adr_q == 32'(urx_pkg::OFS_DATA)) |=> rxIrq)
        else $error("interrupt dropped without a data read");
    a_flush_empty: assert property ($rose(rxPinOverride) |-> !rxIrq [*8])
        else $error("buffer not empty after re-enable");

    cover property ($rose(rxIrq));
    cover property ($fell(rxPinOverride));
    cover property (take && !hwrite && haddr[31:8] != 24'h0);
endmodule

bind urx_rx_core urx_rx_core_assertions urx_rx_core_assertions_i (
    .clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .rxd(rxd),
    .rxPinOverride(rxPinOverride), .rxIrq(rxIrq)
);

`default_nettype wire

// ### verification/urx_rx_core_test.sv
// Self-checking bench for the serial receiver
`default_nettype none

`define CHK(got, exp) begin \
    cmp_count++; \
    if ((got) !== (exp)) begin \
        err_count++; \
        $display("[ERR] t=%0t got=%h exp=%h", $time, (got), (exp)); \
    end \
end

module urx_rx_core_test;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [31:0] A_ST = 32'(urx_pkg::OFS_STATUS);
    localparam logic [31:0] A_CT = 32'(urx_pkg::OFS_CONTROL);
    localparam logic [31:0] A_FM = 32'(urx_pkg::OFS_FORMAT);
    localparam logic [31:0] A_DA = 32'(urx_pkg::OFS_DATA);
    localparam logic [31:0] C_EN = 32'h1 << urx_pkg::CB_RXEN;
    localparam logic [31:0] C_IE = 32'h1 << urx_pkg::CB_IRQEN;
    localparam logic [2:0]  SZT [5] = '{urx_pkg::SZ_5, urx_pkg::SZ_6, urx_pkg::SZ_7,
                                        urx_pkg::SZ_8, urx_pkg::SZ_9};

    logic        clk;
    logic        rst_b;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
    logic        rxd;
    logic        rxPinOverride;
    logic        rxIrq;
    int          err_count;
    int          cmp_count;
    logic [31:0] lfsr;
    logic [31:0] r;
    logic [31:0] ctl;
    logic        dbl;
    logic [11:0] q[$];

    urx_rx_core urx_rx_core_i (
        .clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .rxd(rxd),
        .rxPinOverride(rxPinOverride), .rxIrq(rxIrq)
    );
    urx_tx_model urx_tx_model_i (.clk(clk), .rxd(rxd));

    always #20 clk = ~clk;

    function automatic logic [31:0] rnd();
        lfsr = {lfsr[30:0], ^(lfsr & 32'h80200003)};
        return lfsr;
    endfunction

    function automatic logic [31:0] stat(input logic [11:0] e, input logic v);
        stat = 32'h0;
        stat[urx_pkg::SB_RXC] = v;
        stat[urx_pkg::SB_FE]  = e[urx_pkg::ENT_FE];
        stat[urx_pkg::SB_OVR] = e[urx_pkg::ENT_OVR];
        stat[urx_pkg::SB_PE]  = e[urx_pkg::ENT_PE];
        stat[urx_pkg::SB_DBL] = dbl;
    endfunction

    task automatic summarize;
        if (err_count == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Ready is sampled at the rising edge, before that edge's updates land
    task automatic waitRdy;
        do @(posedge clk); while (hreadyout !== 1'b1);
    endtask

    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
        htrans <= 2'b10;
        hwrite <= w;
        haddr  <= a;
        waitRdy();
        htrans <= 2'b00;
        hwdata <= d;
        waitRdy();
        r = hrdata;
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask

    task automatic rdChk(input logic [31:0] a, input logic [31:0] x);
        xfer(1'b0, a, 32'h0);
        `CHK(r, x)
    endtask

    task automatic frame(input logic [8:0] d, input int nb, input logic pOn,
                         input logic pOdd, input logic pFlip, input logic stop);
        logic [8:0]  m;
        logic [11:0] e;
        m = d & ((9'h1 << nb) - 9'h1);
        e = {1'b0, !stop, pOn & pFlip, m};
        urx_tx_model_i.send(m, nb, dbl ? 8 : 16, pOn, ^m ^ pOdd ^ pFlip, stop);
        // Full buffer plus waiting frame: new frame lost, waiting one flagged
        if (q.size() == 3)
            q[2][urx_pkg::ENT_OVR] = 1'b1;
        else
            q.push_back(e);
    endtask

    task automatic pop;
        logic [11:0] e;
        logic [31:0] c;
        e = q.pop_front();
        c = ctl;
        c[urx_pkg::CB_NINTH] = e[8];
        rdChk(A_ST, stat(e, 1'b1));
        rdChk(A_CT, c);
        rdChk(A_DA, {24'h0, e[7:0]});
    endtask

    initial begin
        repeat (40000) @(posedge clk);
        err_count++;
        summarize();
    end

    initial begin
        logic [2:0] sz;
        logic [5:0] f;
        clk = 1'b0;
        rst_b = 1'b0;
        hsel = 1'b1;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0;
        lfsr = 32'h09929892;
        err_count = 0;
        cmp_count = 0;
        dbl = 1'b0;
        ctl = 32'h0;
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        rdChk(A_ST, 32'h0);
        rdChk(A_CT, 32'h0);
        rdChk(A_FM, 32'(urx_pkg::FORMAT_RST));
        rdChk(32'(urx_pkg::OFS_BAUD), 32'(urx_pkg::BAUD_RST));
        rdChk(32'h100, 32'h0);
        wr(32'(urx_pkg::OFS_BAUD), 32'h0);
        ctl = C_EN | C_IE;
        wr(A_CT, ctl);
        wr(A_ST, 32'hff);
        dbl = 1'b1;
        rdChk(A_ST, stat(12'h0, 1'b0));
        for (int i = 0; i < 10; i++) begin
            r = rnd();
            dbl = (i >= 5);
            sz = SZT[i % 5];
            f = {(i % 3) != 0, (i % 3) == 2, i[0], sz};
            wr(A_FM, {26'h0, f});
            wr(A_ST, {30'h0, dbl, 1'b0});
            frame(r[8:0], (sz == urx_pkg::SZ_9) ? 9 : 5 + int'(sz), f[5], f[4], r[9], (i % 4) != 3);
            `CHK(rxIrq, 1'b1)
            pop();
            rdChk(A_ST, stat(12'h0, 1'b0));
        end
        dbl = 1'b0;
        wr(A_ST, 32'h0);
        wr(A_FM, 32'h3);
        ctl = C_EN;
        wr(A_CT, ctl);
        r = rnd();
        frame(r[8:0], 8, 1'b0, 1'b0, 1'b0, 1'b0);
        `CHK(rxIrq, 1'b0)
        ctl = C_EN | C_IE;
        wr(A_CT, ctl);
        // Enable lands at the edge that ended the write; look one edge later
        @(posedge clk);
        `CHK(rxIrq, 1'b1)
        pop();
        for (int k = 0; k < 4; k++) begin
            r = rnd();
            frame(r[8:0], 8, 1'b0, 1'b0, 1'b0, 1'b1);
        end
        repeat (3) pop();
        `CHK(rxIrq, 1'b0)
        repeat (2) frame(9'h0a5, 8, 1'b0, 1'b0, 1'b0, 1'b1);
        wr(A_CT, C_IE);
        q.delete();
        dbl = 1'b0;
        rdChk(A_ST, stat(12'h0, 1'b0));
        `CHK(rxPinOverride, 1'b0)
        wr(A_CT, ctl);
        fork
            urx_tx_model_i.send(9'h055, 8, 16, 1'b0, 1'b0, 1'b1);
            begin
                repeat (80) @(posedge clk);
                wr(A_CT, C_IE);
            end
        join
        wr(A_CT, ctl);
        rdChk(A_ST, stat(12'h0, 1'b0));
        r = rnd();
        frame(r[8:0], 8, 1'b0, 1'b0, 1'b0, 1'b1);
        pop();
        urx_tx_model_i.glitch(8);
        rdChk(A_ST, stat(12'h0, 1'b0));
        dbl = 1'b1;
        wr(A_ST, 32'h2);
        urx_tx_model_i.glitch(4);
        rdChk(A_ST, stat(12'h0, 1'b0));
        summarize();
    end
endmodule

`default_nettype wire

// ### verification/urx_tx_model.sv
// Remote asynchronous transmitter driving the receive line
`default_nettype none

module urx_tx_model (
    input  wire logic clk,
    output logic      rxd
);
    timeunit 1ns;
    timeprecision 1ps;

    initial rxd = 1'b1;

    task automatic hold(input logic v, input int n);
        rxd <= v;
        repeat (n) @(posedge clk);
    endtask

    // Start, data LSB first, optional parity, one stop, then idle high
    task automatic send(input logic [8:0] d, input int nb, input int bt,
                        input logic pOn, input logic pBit, input logic stop);
        hold(1'b0, bt);
        for (int i = 0; i < nb; i++)
            hold(d[i], bt);
        if (pOn)
            hold(pBit, bt);
        hold(stop, bt);
        hold(1'b1, 2 * bt);
    endtask

    task automatic glitch(input int n);
        hold(1'b0, n);
        hold(1'b1, 32);
    endtask
endmodule

`default_nettype wire
